/* File: src/cspc_ctl.sv */
`timescale 1ns/100ps
// How it works
// - rising enabled pen strobe stores refresh address plus two and raster count
// - an accepted pen strobe sets the pen-accepted flag
// - interrupt appears on the shared cursor pin only during blanking
// - with cursor disabled the shared pin carries only the interrupt
// - tv sync mode accepts external hsync only if held 1000 ns or longer
// - tv sync mode resyncs horizontal display period from vsync in vertical blanking
// - screen one starts at line zero; screens two to four follow start lines
// - equal start lines suppress the partitions that share them
// - two-bit interrupt source select: none, pen, blanking, or either
// - pen-accepted flag clears on reset and on a status read
// - blanking and pen flags set whatever the interrupt select says
// - two-bit partition select enables one to four start addresses
module cspc_ctl (
	// clock and reset
	input logic clk_sys,
	input logic nrst,
	// register port
	input logic [cspc_pkg::AD_W-1:0] reg_addr,
	input logic [cspc_pkg::DW-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [cspc_pkg::DW-1:0] reg_rdata,
	// refresh timing from the controller core
	input cspc_pkg::cspc_pos_t pos,
	input logic disp_active_in,
	input logic vblank_in,
	input logic cursor_in,
	// pins
	input logic pen_strobe_in,
	input logic ext_horiz_sync_in,
	input logic ext_vert_sync_in,
	output logic cursor_irq_out,
	output logic display_active_out,
	// towards the controller core
	output logic hsync_accept,
	output logic hdisp_resync,
	output logic [1:0] screen_sel,
	output logic screen_blank,
	output logic raster_interp_bit,
	// interrupt
	output logic irq
);
	import cspc_pkg::*;

	// all state of the block
	typedef struct packed
	{
		logic [DW-1:0] ctrl;
		logic [LN_W-1:0] scr2;
		logic [LN_W-1:0] scr3;
		logic [LN_W-1:0] scr4;
		logic [MA_W-1:0] pen_addr;
		logic [RA_W-1:0] pen_rast;
		logic pen_accepted_flag;
		logic vert_blank_flag;
		logic [1:0] evt_stat;
		logic [1:0] evt_en;
		logic [DW-1:0] rdata;
		logic pen_prev;
		logic vs_prev;
		logic vb_prev;
		cspc_hs_t hs_st;
		logic [HS_CNT_W-1:0] hs_cnt;
		logic hs_acc;
		logic resync;
		logic pin_out;
		logic disp_out;
		logic [1:0] scr_sel;
		logic scr_blank;
	} cspc_st_t;

	cspc_st_t st_q;
	cspc_st_t st_d;
	cspc_bus_t bus;
	logic [2:0] pins_s;
	logic pen_s;
	logic hs_s;
	logic vs_s;
	logic pen_ev;
	logic vb_ev;
	logic [1:0] irq_src;
	logic irq_lvl;
	logic [1:0] ord_scr;
	logic ord_sup;

	// the sample that leaves idle counts as one, so a minimum-width pulse is accepted
	localparam logic [HS_CNT_W-1:0] HS_LAST = HS_CNT_W'(HSYNC_MIN_CYC - 2);

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// pins are asynchronous to the character clock
	cspc_sync #(.W(3)) u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pins({ext_vert_sync_in, ext_horiz_sync_in, pen_strobe_in}),
		.sync(pins_s)
	);
	assign pen_s = pins_s[0];
	assign hs_s = pins_s[1];
	assign vs_s = pins_s[2];

	cspc_part_order u_order (
		.psel(st_q.ctrl[CTL_PSEL_HI:CTL_PSEL_LO]),
		.start2(st_q.scr2),
		.start3(st_q.scr3),
		.start4(st_q.scr4),
		.line(pos.line),
		.screen(ord_scr),
		.suppress(ord_sup)
	);

	// events on the synchronised pen strobe and on blanking start
	assign pen_ev = st_q.ctrl[CTL_PEN_EN] && pen_s && !st_q.pen_prev;
	assign vb_ev = vblank_in && !st_q.vb_prev;

	// source select gates sticky events; software enable gates them again
	assign irq_src = {st_q.ctrl[CTL_IRQ_BLANK], st_q.ctrl[CTL_IRQ_PEN]};
	assign irq_lvl = |(st_q.evt_stat & st_q.evt_en & irq_src);

	always_comb
	begin
		st_d = st_q;
		st_d.pen_prev = pen_s;
		st_d.vs_prev = vs_s;
		st_d.vb_prev = vblank_in;
		st_d.hs_acc = 1'b0;
		st_d.resync = 1'b0;
		st_d.vert_blank_flag = vblank_in;

		// register writes
		if (bus.wr)
		begin
			case (bus.addr)
				REG_CTRL: st_d.ctrl = bus.wdata;
				REG_SCR2: st_d.scr2 = bus.wdata[LN_W-1:0];
				REG_SCR3: st_d.scr3 = bus.wdata[LN_W-1:0];
				REG_SCR4: st_d.scr4 = bus.wdata[LN_W-1:0];
				REG_EVT_CLR: st_d.evt_stat = st_q.evt_stat & ~bus.wdata[1:0];
				REG_EVT_EN: st_d.evt_en = bus.wdata[1:0];
				default: st_d.ctrl = st_q.ctrl;
			endcase
		end

		// reads answer one cycle later; unmapped offsets read zero
		st_d.rdata = '0;
		if (bus.rd)
		begin
			case (bus.addr)
				REG_CTRL: st_d.rdata = st_q.ctrl;
				REG_STATUS:
				begin
					st_d.rdata[ST_PEN] = st_q.pen_accepted_flag;
					st_d.rdata[ST_VBLANK] = st_q.vert_blank_flag;
					st_d.pen_accepted_flag = 1'b0;
				end
				REG_PEN_LO: st_d.rdata = st_q.pen_addr[7:0];
				REG_PEN_HI: st_d.rdata = {2'h0, st_q.pen_addr[MA_W-1:8]};
				REG_PEN_RAST: st_d.rdata = {3'h0, st_q.pen_rast};
				REG_SCR2: st_d.rdata = {1'b0, st_q.scr2};
				REG_SCR3: st_d.rdata = {1'b0, st_q.scr3};
				REG_SCR4: st_d.rdata = {1'b0, st_q.scr4};
				REG_EVT_STAT: st_d.rdata = {6'h00, st_q.evt_stat};
				REG_EVT_EN: st_d.rdata = {6'h00, st_q.evt_en};
				default: st_d.rdata = '0;
			endcase
		end

		// pen capture; set is applied after the read so a strobe is never lost
		if (pen_ev)
		begin
			st_d.pen_addr = pos.addr + PEN_ADDR_OFS;
			st_d.pen_rast = pos.raster;
			st_d.pen_accepted_flag = 1'b1;
			st_d.evt_stat[EV_PEN] = 1'b1;
		end
		if (vb_ev)
			st_d.evt_stat[EV_VBLANK] = 1'b1;

		// hsync width filter: short pulses never reach the core
		case (st_q.hs_st)
			HS_IDLE:
			begin
				st_d.hs_cnt = '0;
				if (hs_s && st_q.ctrl[CTL_TV_SYNC])
					st_d.hs_st = HS_COUNT;
			end
			HS_COUNT:
			begin
				if (!hs_s || !st_q.ctrl[CTL_TV_SYNC])
					st_d.hs_st = HS_IDLE;
				else if (st_q.hs_cnt == HS_LAST)
				begin
					st_d.hs_acc = 1'b1;
					st_d.hs_st = HS_HELD;
				end
				else
					st_d.hs_cnt = st_q.hs_cnt + 1'b1;
			end
			HS_HELD:
			begin
				// one acceptance per pulse, however long it stays high
				if (!hs_s)
					st_d.hs_st = HS_IDLE;
			end
			default: st_d.hs_st = HS_IDLE;
		endcase

		// vsync edge only counts while vertical blanking runs
		if (st_q.ctrl[CTL_TV_SYNC] && vblank_in && vs_s && !st_q.vs_prev)
			st_d.resync = 1'b1;

		// shared pin: cursor video while displaying, interrupt while blanking
		if (st_q.ctrl[CTL_CURSOR_EN] && disp_active_in)
			st_d.pin_out = cursor_in;
		else
			st_d.pin_out = irq_lvl && !disp_active_in;
		st_d.disp_out = disp_active_in;

		// partition ordering registered towards the core
		st_d.scr_sel = ord_scr;
		st_d.scr_blank = ord_sup;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			st_q <= '0;
			st_q.ctrl <= CTRL_RST;
			st_q.evt_en <= EVT_EN_RST;
			st_q.scr2 <= SCR_RST;
			st_q.scr3 <= SCR_RST;
			st_q.scr4 <= SCR_RST;
			st_q.hs_st <= HS_IDLE;
		end
		else
			st_q <= st_d;
	end

	// outputs, all from flip-flops except the interrupt level
	assign reg_rdata = st_q.rdata;
	assign cursor_irq_out = st_q.pin_out;
	assign display_active_out = st_q.disp_out;
	assign hsync_accept = st_q.hs_acc;
	assign hdisp_resync = st_q.resync;
	assign screen_sel = st_q.scr_sel;
	assign screen_blank = st_q.scr_blank;
	assign raster_interp_bit = st_q.ctrl[CTL_INTERP];
	assign irq = irq_lvl;

	// helper: length of the current synchronised hsync high run
	int hs_run;
	always_ff @(posedge clk_sys)
	begin
		if (!nrst || !hs_s)
			hs_run <= 0;
		else if (hs_run < 1000)
			hs_run <= hs_run + 1;
	end

	a_pen_addr_plus2: assert property (@(posedge clk_sys) disable iff (!nrst)
		pen_ev |=> st_q.pen_addr == $past(pos.addr) + PEN_ADDR_OFS)
		else $error("pen address not captured as address plus two");

	a_pen_raster_cap: assert property (@(posedge clk_sys) disable iff (!nrst)
		pen_ev |=> st_q.pen_rast == $past(pos.raster))
		else $error("pen raster not captured");

	a_pen_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		pen_ev |=> st_q.pen_accepted_flag)
		else $error("pen flag missing after strobe");

	a_pin_blank_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		(disp_active_in && st_q.ctrl[CTL_CURSOR_EN]) |=> cursor_irq_out == $past(cursor_in))
		else $error("interrupt shown on pin during display");

	a_pin_pure_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
		!st_q.ctrl[CTL_CURSOR_EN] |=> cursor_irq_out == $past(irq && !disp_active_in))
		else $error("pin not a pure interrupt with cursor off");

	a_hsync_width_ok: assert property (@(posedge clk_sys) disable iff (!nrst)
		hsync_accept |-> hs_run >= HSYNC_MIN_CYC)
		else $error("hsync accepted before minimum width");

	a_vsync_in_blank: assert property (@(posedge clk_sys) disable iff (!nrst)
		hdisp_resync |-> $past(vblank_in) && $past(st_q.ctrl[CTL_TV_SYNC]))
		else $error("resync outside vertical blanking");

	a_screen_one_top: assert property (@(posedge clk_sys) disable iff (!nrst)
		(pos.line == 7'h00 && st_q.scr2 != 7'h00 && st_q.scr3 != 7'h00 && st_q.scr4 != 7'h00)
		|=> screen_sel == 2'h0)
		else $error("line zero not on screen one");

	a_dup_suppress: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_q.ctrl[1:0] == 2'h3 && st_q.scr2 == st_q.scr3 && pos.line >= st_q.scr2
		&& st_q.scr4 > pos.line) |=> screen_blank)
		else $error("equal start lines not suppressed");

	a_irq_src_none: assert property (@(posedge clk_sys) disable iff (!nrst)
		irq_src == 2'h0 |-> !irq)
		else $error("interrupt with no source selected");

	a_flag_clr_read: assert property (@(posedge clk_sys) disable iff (!nrst)
		(bus.rd && bus.addr == REG_STATUS && !pen_ev) |=> !st_q.pen_accepted_flag)
		else $error("pen flag not cleared by status read");

	a_psel_single: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_q.ctrl[1:0] == 2'h0 && !bus.wr) |=> screen_sel == 2'h0 && !screen_blank)
		else $error("extra partition with one start address");

	a_hs_short_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_q.hs_st == HS_COUNT && !hs_s) |=> !hsync_accept)
		else $error("short hsync pulse accepted");

	a_hs_accept_once: assert property (@(posedge clk_sys) disable iff (!nrst)
		hsync_accept |=> !hsync_accept)
		else $error("hsync accepted twice in a row");

	a_resync_tv_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		!st_q.ctrl[CTL_TV_SYNC] |=> !hdisp_resync)
		else $error("resync outside tv sync mode");

	a_pin_display_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
		(disp_active_in && !(st_q.ctrl[CTL_CURSOR_EN] && cursor_in)) |=> !cursor_irq_out)
		else $error("shared pin high during display without cursor");

	a_vblank_evt_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		vb_ev |=> st_q.evt_stat[EV_VBLANK])
		else $error("blanking event not recorded");

	a_pen_evt_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		pen_ev |=> st_q.evt_stat[EV_PEN])
		else $error("pen event not recorded");

	a_psel_two_max: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_q.ctrl[1:0] == 2'h1 |=> screen_sel <= 2'h1)
		else $error("screen beyond two with two start addresses");

	a_irq_no_enable: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_q.evt_en == 2'h0 |-> !irq)
		else $error("interrupt with no event enabled");

endmodule : cspc_ctl

/* File: src/cspc_pkg.sv */
package cspc_pkg;

	// widths of the refresh counters this block observes and of its register port
	localparam int MA_W = 14;
	localparam int RA_W = 5;
	localparam int LN_W = 7;
	localparam int AD_W = 4;
	localparam int DW = 8;

	// register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_PEN_LO = 4'h2;
	localparam logic [3:0] REG_PEN_HI = 4'h3;
	localparam logic [3:0] REG_PEN_RAST = 4'h4;
	localparam logic [3:0] REG_SCR2 = 4'h5;
	localparam logic [3:0] REG_SCR3 = 4'h6;
	localparam logic [3:0] REG_SCR4 = 4'h7;
	localparam logic [3:0] REG_EVT_STAT = 4'h8;
	localparam logic [3:0] REG_EVT_CLR = 4'h9;
	localparam logic [3:0] REG_EVT_EN = 4'ha;

	// control register fields
	localparam int CTL_PSEL_LO = 0;
	localparam int CTL_PSEL_HI = 1;
	localparam int CTL_IRQ_PEN = 2;
	localparam int CTL_IRQ_BLANK = 3;
	localparam int CTL_TV_SYNC = 4;
	localparam int CTL_CURSOR_EN = 5;
	localparam int CTL_INTERP = 6;
	localparam int CTL_PEN_EN = 7;

	// status and event bit positions
	localparam int ST_PEN = 0;
	localparam int ST_VBLANK = 1;
	localparam int EV_PEN = 0;
	localparam int EV_VBLANK = 1;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] EVT_EN_RST = 2'h0;
	localparam logic [6:0] SCR_RST = 7'h00;

	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int HSYNC_MIN_NS = 1000;
	localparam int HSYNC_MIN_CYC = (HSYNC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HS_CNT_W = 5;
	localparam logic [MA_W-1:0] PEN_ADDR_OFS = 14'h0002;

	// external hsync width filter
	typedef enum logic [1:0]
	{
		HS_IDLE = 2'b00,
		HS_COUNT = 2'b01,
		HS_HELD = 2'b10
	} cspc_hs_t;

	// refresh position as seen by the block
	typedef struct packed
	{
		logic [MA_W-1:0] addr;
		logic [RA_W-1:0] raster;
		logic [LN_W-1:0] line;
	} cspc_pos_t;

	// register bus request
	typedef struct packed
	{
		logic [AD_W-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} cspc_bus_t;

endpackage : cspc_pkg

/* File: src/cspc_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for pins from outside the clock domain
module cspc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input logic clk_sys,
	input logic nrst,
	// pins and synchronised levels
	input logic [W-1:0] pins,
	output logic [W-1:0] sync
);
	import cspc_pkg::*;

	logic [1:0][W-1:0] st_q;
	logic [1:0][W-1:0] st_d;

	// stage 0 is read only by stage 1
	always_comb
	begin
		st_d = {st_q[0], pins};
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync = st_q[1];

endmodule : cspc_sync

/* File: src/cspc_part_order.sv */
`timescale 1ns/100ps
// picks the screen partition that owns the current character line
module cspc_part_order (
	// partition setup
	input logic [1:0] psel,
	input logic [cspc_pkg::LN_W-1:0] start2,
	input logic [cspc_pkg::LN_W-1:0] start3,
	input logic [cspc_pkg::LN_W-1:0] start4,
	// current line and result
	input logic [cspc_pkg::LN_W-1:0] line,
	output logic [1:0] screen,
	output logic suppress
);
	import cspc_pkg::*;

	logic [3:0][LN_W-1:0] starts;
	logic [3:0] enabled;

	// screen k is enabled when the select covers it
	function automatic logic [3:0] part_enables(input logic [1:0] sel);
		logic [3:0] en;
		en = 4'h0;
		for (int k = 0; k < 4; k++)
			en[k] = (k <= int'(sel));
		return en;
	endfunction : part_enables

	assign starts = {start4, start3, start2, 7'h00};
	assign enabled = part_enables(psel);

	// latest enabled start not past the line wins; screen 1 owns line 0 unless another enabled start is 0
	always_comb
	begin
		screen = 2'h0;
		suppress = 1'b0;
		for (int k = 1; k < 4; k++)
			if (enabled[k] && starts[k] <= line && starts[k] >= starts[screen])
				screen = 2'(k);
		// a shared start value hides every partition that shares it
		for (int k = 0; k < 4; k++)
			if (enabled[k] && k != int'(screen) && starts[k] == starts[screen])
				suppress = 1'b1;
	end

endmodule : cspc_part_order

/* File: verif/cspc_crt_model.sv */
`timescale 1ns/100ps
// stand-in for the raster counters and monitor timing that feed the block
module cspc_crt_model (
	// clock and reset
	input logic clk_sys,
	input logic nrst,
	// bench parks the raster at a chosen position, so pen captures are predictable
	input logic [15:0] cnt_set,
	// refresh timing
	output cspc_pkg::cspc_pos_t pos,
	output logic disp_active,
	output logic vblank,
	output logic cursor
);
	import cspc_pkg::*;
	logic [15:0] cnt_q;
	// position register; low nibble is the column, top seven bits the line
	always_ff @(posedge clk_sys)
		if (!nrst)
			cnt_q <= 16'h0000;
		else
			cnt_q <= cnt_set;
	// outside vertical blanking a horizontal display period exists: ten of sixteen columns
	assign vblank = cnt_q[15:14] == 2'b11;
	assign disp_active = !vblank && cnt_q[3:0] < 4'ha;
	assign cursor = cnt_q[3:0] == 4'h3;
	assign pos = '{addr: cnt_q[13:0], raster: cnt_q[8:4], line: cnt_q[15:9]};
endmodule : cspc_crt_model

/* File: verif/tb_crt_sync_pen_partition_ctl.sv */
`timescale 1ns/100ps
module tb_crt_sync_pen_partition_ctl;
	import cspc_pkg::*;
	// partition case: setup and line beside the expected owner and blanking
	typedef struct packed
	{
		logic [1:0] psel;
		logic [6:0] s2;
		logic [6:0] s3;
		logic [6:0] s4;
		logic [6:0] line;
		logic [1:0] scr;
		logic blank;
	} cspc_prow_t;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic pen = 1'b0;
	logic hs = 1'b0;
	logic vs = 1'b0;
	logic [15:0] cnt_set = 16'h1204;
	cspc_pos_t pos;
	logic disp_active, vblank, cursor, cur_out, irq, hs_acc, resync, blank;
	logic [1:0] scr;
	logic interp, disp_out;
	logic [7:0] rd;
	int failures = 0;
	int compares = 0;
	int n_acc = 0;
	int n_res = 0;
	cspc_prow_t rows [8] = '{
		'{2'h3, 7'h05, 7'h02, 7'h08, 7'h00, 2'h0, 1'b0},
		'{2'h3, 7'h05, 7'h02, 7'h08, 7'h03, 2'h2, 1'b0},
		'{2'h3, 7'h05, 7'h02, 7'h08, 7'h06, 2'h1, 1'b0},
		'{2'h3, 7'h05, 7'h02, 7'h08, 7'h09, 2'h3, 1'b0},
		'{2'h1, 7'h05, 7'h02, 7'h08, 7'h09, 2'h1, 1'b0},
		'{2'h0, 7'h05, 7'h02, 7'h08, 7'h09, 2'h0, 1'b0},
		'{2'h3, 7'h04, 7'h04, 7'h08, 7'h05, 2'h2, 1'b1},
		'{2'h3, 7'h04, 7'h04, 7'h08, 7'h09, 2'h3, 1'b0}};

	cspc_crt_model cspc_crt_model_inst (.clk_sys(clk_sys), .nrst(nrst), .cnt_set(cnt_set),
		.pos(pos), .disp_active(disp_active), .vblank(vblank), .cursor(cursor));
	cspc_ctl cspc_ctl_inst (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pos(pos), .disp_active_in(disp_active), .vblank_in(vblank), .cursor_in(cursor),
		.pen_strobe_in(pen), .ext_horiz_sync_in(hs), .ext_vert_sync_in(vs),
		.cursor_irq_out(cur_out), .display_active_out(disp_out), .hsync_accept(hs_acc),
		.hdisp_resync(resync), .screen_sel(scr), .screen_blank(blank),
		.raster_interp_bit(interp), .irq(irq));

	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;
	// count one-cycle pulses so a repeated accept shows up
	always @(posedge clk_sys)
		if (hs_acc === 1'b1)
			n_acc++;
	always @(posedge clk_sys)
		if (resync === 1'b1)
			n_res++;

	task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : bus_wr
	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : bus_rd
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cycles
	task automatic park(input logic [15:0] c);
		@(posedge clk_sys);
		cnt_set <= c;
		cycles(3);
	endtask : park
	// pin 0 pen, 1 hsync, 2 vsync; held n cycles then a quiet gap
	task automatic pin_pulse(input int sel, input int n);
		@(posedge clk_sys);
		pen <= sel == 0;
		hs <= sel == 1;
		vs <= sel == 2;
		cycles(n);
		{pen, hs, vs} <= 3'b000;
		cycles(30);
	endtask : pin_pulse
	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// no wait may hang the run
	initial
	begin
		cycles(100000);
		failures++;
		close_out;
	end

	initial
	begin
		cycles(6);
		nrst <= 1'b1;
		cycles(2);
		chk_bit(irq, 1'b0);
		bus_rd(REG_CTRL, rd);
		chk_data(rd, CTRL_RST);
		bus_rd(REG_STATUS, rd);
		chk_data(rd, 8'h00);
		bus_rd(REG_EVT_EN, rd);
		chk_data(rd, {6'h00, EVT_EN_RST});
		bus_rd(4'hf, rd);
		chk_data(rd, 8'h00);
		$display("test reset done");
		foreach (rows[i])
		begin
			bus_wr(REG_CTRL, {6'h00, rows[i].psel});
			bus_wr(REG_SCR2, {1'b0, rows[i].s2});
			bus_wr(REG_SCR3, {1'b0, rows[i].s3});
			bus_wr(REG_SCR4, {1'b0, rows[i].s4});
			bus_rd(REG_SCR3, rd);
			chk_data(rd, {1'b0, rows[i].s3});
			park({rows[i].line, 9'h004});
			chk_data({6'h00, scr}, {6'h00, rows[i].scr});
			chk_bit(blank, rows[i].blank);
		end
		$display("test partitions done");
		park(16'h1234);
		bus_wr(REG_EVT_EN, 8'h03);
		bus_wr(REG_CTRL, 8'h04);
		pin_pulse(0, 4);
		bus_rd(REG_STATUS, rd);
		chk_data(rd, 8'h00);
		bus_wr(REG_CTRL, 8'h80);
		pin_pulse(0, 4);
		bus_rd(REG_STATUS, rd);
		chk_data(rd, 8'h01);
		chk_bit(irq, 1'b0);
		bus_rd(REG_STATUS, rd);
		chk_data(rd, 8'h00);
		bus_rd(REG_PEN_LO, rd);
		chk_data(rd, 8'h36);
		bus_rd(REG_PEN_HI, rd);
		chk_data(rd, 8'h12);
		bus_rd(REG_PEN_RAST, rd);
		chk_data(rd, 8'h03);
		bus_wr(REG_CTRL, 8'h84);
		cycles(2);
		chk_bit(irq, 1'b1);
		chk_bit(cur_out, 1'b0);
		chk_bit(interp, 1'b0);
		park(16'h123c);
		chk_bit(cur_out, 1'b1);
		chk_bit(disp_out, 1'b0);
		park(16'h1233);
		chk_bit(cur_out, 1'b0);
		chk_bit(disp_out, 1'b1);
		bus_wr(REG_CTRL, 8'ha4);
		park(16'h1233);
		chk_bit(cur_out, 1'b1);
		park(16'h1234);
		chk_bit(cur_out, 1'b0);
		park(16'h123c);
		chk_bit(cur_out, 1'b1);
		bus_wr(REG_EVT_CLR, 8'h01);
		cycles(1);
		chk_bit(irq, 1'b0);
		$display("test pen done");
		bus_wr(REG_CTRL, 8'h10);
		pin_pulse(1, 19);
		chk_data(n_acc[7:0], 8'h00);
		pin_pulse(1, 20);
		chk_data(n_acc[7:0], 8'h01);
		pin_pulse(1, 24);
		chk_data(n_acc[7:0], 8'h02);
		$display("test hsync done");
		bus_wr(REG_EVT_CLR, 8'h03);
		bus_wr(REG_CTRL, 8'h18);
		pin_pulse(2, 4);
		chk_data(n_res[7:0], 8'h00);
		park(16'hc804);
		chk_bit(irq, 1'b1);
		bus_rd(REG_STATUS, rd);
		chk_data(rd, 8'h02);
		pin_pulse(2, 4);
		chk_data(n_res[7:0], 8'h01);
		$display("test vsync done");
		// a pen capture just before a mid-run reset must not survive it
		bus_wr(REG_CTRL, 8'h80);
		pin_pulse(0, 4);
		@(posedge clk_sys);
		nrst <= 1'b0;
		cycles(2);
		nrst <= 1'b1;
		cycles(2);
		bus_rd(REG_STATUS, rd);
		chk_data(rd, 8'h02);
		bus_rd(REG_CTRL, rd);
		chk_data(rd, CTRL_RST);
		$display("test reset again done");
		close_out;
	end
endmodule : tb_crt_sync_pen_partition_ctl
